// ---- rtl/half_bridge_serial_control.sv ----
/*
 * Serial control and status logic of a triple half-bridge driver.
 * Assumes the serial clock, chip select, data and standby pins are asynchronous
 * to core_clk and that the serial clock is at most 2 MHz; monitor inputs are
 * comparator levels that may also be asynchronous.
 */
`timescale 1ns/10ps

// Summary of operation
// - falling chip select starts a fresh shift sequence
// - serial_in is sampled on every falling serial clock edge
// - new control word is applied only at rising chip select
// - serial_out tristate while deselected, enabled at falling chip select
// - serial_out changes only on rising serial clock edges
// - status word shifted out lsb first, temp_prewarning first
// - control bits 1 to 6 turn the six switches on
// - control bit 13 enables overcurrent shutdown; other upper bits unused
// - status_clear clears supply fail, open load and short circuit flags
// - status bits 1 to 6 show actual switch states
// - after reset, overcurrent shutdown enabled and bits 0 to 6 zero
// - filtered undervoltage sets supply fail and disables all switches
// - supply recovery re-enables outputs; supply fail flag stays sticky
// - filtered low current in an on switch sets sticky open load
// - temp_prewarning follows the warning comparator, not sticky
// - aborted short transfer leaves control and status unchanged
// - thermal shutdown latches all off until cool and status_clear
// - enabled overcurrent shutdown switches the stage off, sets short flag
// - disabled shutdown still sets short flag, outputs unaffected
// - status_clear clears short flag and re-enables shut-down stages
// - standby low turns all off, clears status; release resets device
// - standby_control low means standby, high means normal operation
module half_bridge_serial_control #(
    parameter int UV_CYCLES = half_bridge_pkg::UV_DELAY_CYC,
    parameter int SD_CYCLES = half_bridge_pkg::SD_DELAY_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic standby_control,
    input wire half_bridge_pkg::monitor_t monitor,
    output logic serial_out_o,
    output logic serial_out_oe,
    output logic [half_bridge_pkg::NUM_SW-1:0] switch_on,
    output logic [half_bridge_pkg::NUM_SW-1:0] switch_hiz
);
    import half_bridge_pkg::*;

    // filter counters are 16 bits wide, so longer delays cannot be served
    if (UV_CYCLES < 1 || SD_CYCLES < 1 || UV_CYCLES > 65535 || SD_CYCLES > 65535) begin : g_bad_delay
        $error("fault delay counts must lie in 1..65535");
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    localparam int NSYNC = 4 + 1 + 2 + 2 * NUM_SW;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    // select idles high, every other pin low: no false edge or fault right after reset
    localparam logic [NSYNC-1:0] SYNC_IDLE = {1'b1, {(NSYNC-1){1'b0}}};
    logic cs_n_s, sclk_s, sdi_s, stby_s, uv_s, tw_s, tsd_s;
    logic [NUM_SW-1:0] oc_s, ucur_s;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
        end else begin
            sync1_reg <= {chip_select_n, serial_clk, serial_in, standby_control,
                          monitor.supply_low, monitor.temp_warn, monitor.temp_shutdown,
                          monitor.overcurrent, monitor.undercurrent};
            sync2_reg <= sync1_reg;
        end
    end

    assign {cs_n_s, sclk_s, sdi_s, stby_s, uv_s, tw_s, tsd_s, oc_s, ucur_s} = sync2_reg;

    // ****************************************************************
    // edge detection and internal reset
    // ****************************************************************
    logic cs_n_d_reg, sclk_d_reg, stby_d_reg;
    logic cs_fall, cs_rise, sclk_fall, sclk_rise, por;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_d_reg <= 1'b1;
            sclk_d_reg <= 1'b0;
            stby_d_reg <= 1'b0;
        end else begin
            cs_n_d_reg <= cs_n_s;
            sclk_d_reg <= sclk_s;
            stby_d_reg <= stby_s;
        end
    end

    assign cs_fall = cs_n_d_reg && !cs_n_s;
    assign cs_rise = !cs_n_d_reg && cs_n_s;
    assign sclk_fall = sclk_d_reg && !sclk_s && !cs_n_s;
    assign sclk_rise = !sclk_d_reg && sclk_s && !cs_n_s;
    assign por = !stby_s || (stby_s && !stby_d_reg);

    // ****************************************************************
    // serial link
    // ****************************************************************
    link_state_t state_reg, state_next;
    logic [WORD_W-1:0] rx_reg, rx_next, tx_reg, tx_next;
    logic [BITCNT_W-1:0] cnt_reg, cnt_next;
    logic out_reg, out_next, oe_reg, oe_next;
    logic [WORD_W-1:0] ctl_reg, ctl_next;
    logic [WORD_W-1:0] status_word;
    logic apply;

    always_comb begin
        state_next = state_reg;
        rx_next = rx_reg;
        tx_next = tx_reg;
        cnt_next = cnt_reg;
        out_next = out_reg;
        oe_next = oe_reg;
        apply = 1'b0;
        case (state_reg)
            LINK_IDLE: begin
                if (cs_fall) begin
                    state_next = LINK_SHIFT;
                    cnt_next = '0;
                    tx_next = status_word;
                    out_next = status_word[ST_TEMP];
                    oe_next = 1'b1;
                end
            end
            LINK_SHIFT: begin
                if (cs_rise) begin
                    state_next = LINK_IDLE;
                    oe_next = 1'b0;
                    apply = (cnt_reg == WORD_BITS);
                end else begin
                    if (sclk_fall) begin
                        rx_next = {serial_in_bit(sdi_s), rx_reg[WORD_W-1:1]};
                        if (cnt_reg != WORD_BITS) begin
                            cnt_next = cnt_reg + 5'h01;
                        end
                    end
                    if (sclk_rise) begin
                        tx_next = {1'b0, tx_reg[WORD_W-1:1]};
                        out_next = tx_reg[1];
                    end
                end
            end
            default: begin
                state_next = LINK_IDLE;
                oe_next = 1'b0;
            end
        endcase
    end

    function automatic logic serial_in_bit(input logic b);
        return b;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= LINK_IDLE;
            rx_reg <= '0;
            tx_reg <= '0;
            cnt_reg <= '0;
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else if (por) begin
            state_reg <= LINK_IDLE;
            cnt_reg <= '0;
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign serial_out_o = out_reg;
    assign serial_out_oe = oe_reg;

    // ****************************************************************
    // control register and protection
    // ****************************************************************
    logic clear_req;
    logic [NUM_SW-1:0] sc_off_reg, sc_off_next;
    logic tsd_latch_reg, tsd_latch_next;
    logic uv_flag_reg, uv_flag_next, ol_flag_reg, ol_flag_next, sc_flag_reg, sc_flag_next;
    logic [15:0] uv_cnt_reg, uv_cnt_next;
    logic [15:0] ol_cnt_reg [NUM_SW];
    logic [15:0] oc_cnt_reg [NUM_SW];
    logic [NUM_SW-1:0] ol_hit, oc_hit, cmd_on, act_on;
    logic uv_hit;

    assign clear_req = apply && rx_reg[CTL_CLEAR];
    assign cmd_on = ctl_reg[CTL_SW_LO +: NUM_SW];

    always_comb begin
        ctl_next = ctl_reg;
        if (apply) begin
            ctl_next = CTL_RESET & '0;
            ctl_next[CTL_CLEAR] = rx_reg[CTL_CLEAR];
            ctl_next[CTL_SW_LO +: NUM_SW] = rx_reg[CTL_SW_LO +: NUM_SW];
            ctl_next[CTL_OCS] = rx_reg[CTL_OCS];
        end
    end

    assign uv_hit = uv_s && (uv_cnt_reg == 16'(UV_CYCLES - 1));
    assign uv_cnt_next = !uv_s ? 16'h0000 : (uv_hit ? uv_cnt_reg : uv_cnt_reg + 16'h0001);

    generate
        for (genvar i = 0; i < NUM_SW; i++) begin : g_filt
            assign ol_hit[i] = act_on[i] && ucur_s[i] && (ol_cnt_reg[i] == 16'(SD_CYCLES - 1));
            assign oc_hit[i] = act_on[i] && oc_s[i] && (oc_cnt_reg[i] == 16'(SD_CYCLES - 1));
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ol_cnt_reg[i] <= 16'h0000;
                    oc_cnt_reg[i] <= 16'h0000;
                end else begin
                    ol_cnt_reg[i] <= (!(act_on[i] && ucur_s[i]) || por) ? 16'h0000 :
                        (ol_hit[i] ? ol_cnt_reg[i] : ol_cnt_reg[i] + 16'h0001);
                    oc_cnt_reg[i] <= (!(act_on[i] && oc_s[i]) || por) ? 16'h0000 :
                        (oc_hit[i] ? oc_cnt_reg[i] : oc_cnt_reg[i] + 16'h0001);
                end
            end
        end
    endgenerate

    always_comb begin
        sc_off_next = sc_off_reg;
        tsd_latch_next = tsd_latch_reg;
        uv_flag_next = uv_flag_reg;
        ol_flag_next = ol_flag_reg;
        sc_flag_next = sc_flag_reg;
        // clear first, so a same-cycle event wins below
        if (clear_req) begin
            uv_flag_next = 1'b0;
            ol_flag_next = 1'b0;
            sc_flag_next = 1'b0;
            sc_off_next = '0;
            if (!tsd_s) begin
                tsd_latch_next = 1'b0;
            end
        end
        if (uv_hit) begin
            uv_flag_next = 1'b1;
        end
        if (|ol_hit) begin
            ol_flag_next = 1'b1;
        end
        if (|oc_hit) begin
            sc_flag_next = 1'b1;
            if (ctl_reg[CTL_OCS]) begin
                sc_off_next = sc_off_next | oc_hit;
            end
        end
        if (tsd_s) begin
            tsd_latch_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= CTL_RESET;
            sc_off_reg <= '0;
            tsd_latch_reg <= 1'b0;
            uv_flag_reg <= 1'b0;
            ol_flag_reg <= 1'b0;
            sc_flag_reg <= 1'b0;
            uv_cnt_reg <= 16'h0000;
        end else if (por) begin
            ctl_reg <= CTL_RESET;
            sc_off_reg <= '0;
            tsd_latch_reg <= 1'b0;
            uv_flag_reg <= 1'b0;
            ol_flag_reg <= 1'b0;
            sc_flag_reg <= 1'b0;
            uv_cnt_reg <= 16'h0000;
        end else begin
            ctl_reg <= ctl_next;
            sc_off_reg <= sc_off_next;
            tsd_latch_reg <= tsd_latch_next;
            uv_flag_reg <= uv_flag_next;
            ol_flag_reg <= ol_flag_next;
            sc_flag_reg <= sc_flag_next;
            uv_cnt_reg <= uv_cnt_next;
        end
    end

    // gating of outputs
    // undervoltage drops outputs only once its filter has run out, even with the sticky flag still set
    assign act_on = cmd_on & ~sc_off_reg & {NUM_SW{!uv_hit && !tsd_latch_reg && !por}};
    assign switch_on = act_on;
    assign switch_hiz = {NUM_SW{!stby_s}} | ~act_on;

    always_comb begin
        status_word = '0;
        status_word[ST_TEMP] = tw_s;
        status_word[ST_SW_LO +: NUM_SW] = act_on;
        status_word[ST_SHORT] = sc_flag_reg;
        status_word[ST_OPEN] = ol_flag_reg;
        status_word[ST_SUPPLY] = uv_flag_reg;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_deselect;
        state_reg == LINK_SHIFT && cs_rise;
    endsequence

    chk_tristate_deselect: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_deselect |=> !serial_out_oe) else $error("serial_out still driven after deselect");
    chk_drive_select: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == LINK_IDLE && cs_fall && !por) |=> serial_out_oe && serial_out_o == $past(tw_s))
        else $error("serial_out not enabled with first status bit");
    chk_out_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
        (serial_out_oe && !sclk_rise && !cs_rise && !por) |=> $stable(serial_out_o))
        else $error("serial_out changed without rising serial clock");
    chk_short_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_deselect and cnt_reg != WORD_BITS && !por) |=> $stable(ctl_reg))
        else $error("aborted transfer changed control register");
    chk_reset_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        por |=> ctl_reg == CTL_RESET) else $error("control not reset to default");
    chk_clear_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clear_req && !uv_hit && !(|ol_hit) && !(|oc_hit) && !por) |=>
        !uv_flag_reg && !ol_flag_reg && !sc_flag_reg) else $error("status_clear left a flag");
    chk_short_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        (|oc_hit && ctl_reg[CTL_OCS] && !por) |=> sc_flag_reg && ((sc_off_reg & $past(oc_hit)) != 0))
        else $error("overcurrent shutdown did not act");
    chk_short_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        (|oc_hit && !ctl_reg[CTL_OCS] && !clear_req && !por) |=> sc_flag_reg && $stable(sc_off_reg))
        else $error("overcurrent with shutdown disabled misbehaved");
    chk_standby_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        !stby_s |-> switch_on == '0 && &switch_hiz) else $error("switch on in standby");
    chk_supply_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        (uv_flag_reg && !clear_req && !por) |=> uv_flag_reg) else $error("supply fail flag dropped");
    chk_supply_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (uv_hit && !por) |-> switch_on == '0 ##1 uv_flag_reg)
        else $error("filtered undervoltage left a switch on or no flag");
endmodule

// ---- pkg/half_bridge_pkg.sv ----
/*
 * Shared constants and types for the triple half-bridge serial control block.
 * Assumes one 50 MHz core clock; serial pins are asynchronous to it.
 */
package half_bridge_pkg;
    localparam int WORD_W = 16;
    localparam int NUM_SW = 6;
    localparam int BITCNT_W = 5;
    // control word fields
    localparam int CTL_CLEAR = 0;
    localparam int CTL_SW_LO = 1;
    localparam int CTL_OCS = 13;
    // status word fields
    localparam int ST_TEMP = 0;
    localparam int ST_SW_LO = 1;
    localparam int ST_SHORT = 13;
    localparam int ST_OPEN = 14;
    localparam int ST_SUPPLY = 15;
    localparam logic [15:0] CTL_RESET = 16'h2000;
    localparam logic [4:0] WORD_BITS = 5'h10;
    // fault filter delays, in microseconds, with the derived cycle counts
    localparam int CLK_MHZ = 50;
    localparam int UV_DELAY_US = 10;
    localparam int SD_DELAY_US = 10;
    localparam int UV_DELAY_CYC = UV_DELAY_US * CLK_MHZ;
    localparam int SD_DELAY_CYC = SD_DELAY_US * CLK_MHZ;

    // analog monitor inputs, already digital comparator levels
    typedef struct packed {
        logic supply_low;
        logic temp_warn;
        logic temp_shutdown;
        logic [5:0] overcurrent;
        logic [5:0] undercurrent;
    } monitor_t;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b01,
        LINK_SHIFT = 2'b10
    } link_state_t;
endpackage

// ---- bench/host_model.sv ----
/*
 * Behavioural host serial master for the half-bridge control block.
 * Assumes it is paced by core_clk; the bench resolves nothing else on its pins.
 */
`timescale 1ns/10ps

module host_model (
    input wire logic core_clk,
    output logic chip_select_n,
    output logic serial_clk,
    output logic serial_in,
    input wire logic serial_out_o,
    input wire logic serial_out_oe
);
    // serial clock stands low outside frames, select idles high
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end

    // the data line has no pull: a released line reads the inverse of the last bit
    wire logic do_line = serial_out_oe ? serial_out_o : ~serial_out_o;

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // one frame of nbits clocks; fewer than 16 is an early abort
    task automatic frame(input logic [15:0] ctl, input int nbits,
                         output logic [15:0] st, output logic ok);
        logic mid;
        int i;
        st = 16'h0000;
        ok = (serial_out_oe === 1'b0);
        chip_select_n = 1'b0;
        tick(8);
        st[0] = do_line;
        for (i = 0; i < nbits; i++) begin
            st[i] = do_line;
            ok = ok & (serial_out_oe === 1'b1);
            serial_in = ctl[i];
            serial_clk = 1'b1;
            tick(4);
            serial_clk = 1'b0;
            mid = do_line;
            tick(4);
            ok = ok & (mid === do_line);
        end
        serial_in = ~serial_in;
        chip_select_n = 1'b1;
        tick(8);
        ok = ok & (serial_out_oe === 1'b0);
    endtask
endmodule

// ---- bench/tb_half_bridge_serial_control.sv ----
/*
 * Self-checking bench for the half-bridge serial control block.
 * Assumes host_model and the block are compiled first; fault filters set to 4 cycles.
 */
`timescale 1ns/10ps

module tb_half_bridge_serial_control;
    import half_bridge_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic standby_control = 1'b1;
    monitor_t monitor = '0;
    logic chip_select_n, serial_clk, serial_in, serial_out_o, serial_out_oe, ok;
    logic [NUM_SW-1:0] switch_on, switch_hiz;
    logic [15:0] st, w;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int k;

    half_bridge_serial_control #(.UV_CYCLES(4), .SD_CYCLES(4)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .chip_select_n(chip_select_n),
        .serial_clk(serial_clk), .serial_in(serial_in), .standby_control(standby_control),
        .monitor(monitor), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
        .switch_on(switch_on), .switch_hiz(switch_hiz));

    host_model i_host (
        .core_clk(core_clk), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
        .serial_in(serial_in), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] exp_st(input logic [5:0] sw, input logic tp,
                                           input logic sc, input logic ol, input logic sf);
        return {sf, ol, sc, 6'h00, sw, tp};
    endfunction

    // unused bits are filled at random: the block must ignore them
    function automatic logic [15:0] ctl(input logic [5:0] sw, input logic ocs, input logic clr);
        logic [15:0] r;
        r = 16'($urandom) & 16'hDF80;
        return r | {2'h0, ocs, 6'h00, sw, clr};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic xfer(input logic [15:0] c, input int nbits);
        i_host.frame(c, nbits, st, ok);
        check(16'(ok), 16'h0001, "output enable or bit timing");
        tick(8);
    endtask

    // 15-bit frame: reads all but bit 15 and is discarded
    task automatic read_st(input logic [15:0] exp);
        xfer(16'($urandom), 15);
        check({1'b0, st[14:0]}, {1'b0, exp[14:0]}, "status word");
    endtask

    task automatic sw_is(input logic [5:0] exp, input string msg);
        check(16'(switch_on), 16'(exp), msg);
        check(16'(switch_hiz), {10'h000, ~exp}, msg);
    endtask

    task automatic close_out;
        $display("TB: %0d checks, %0d mismatches", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // a hang counts as a failure
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        void'($urandom(14));
        tick(16);
        rst_n = 1'b1;
        tick(8);
        sw_is(6'h00, "after reset");
        read_st(16'h0000);
        $display("TB: reset test done");

        for (k = 0; k < 8; k++) begin
            w = ctl(6'($urandom), 1'b1, 1'b0);
            xfer(w, 16);
            sw_is(w[6:1], "random word applied");
            read_st(exp_st(w[6:1], 1'b0, 1'b0, 1'b0, 1'b0));
            sw_is(w[6:1], "aborted frame kept word");
        end
        $display("TB: random word test done");

        monitor.temp_warn = 1'b1;
        tick(8);
        read_st(exp_st(w[6:1], 1'b1, 1'b0, 1'b0, 1'b0));
        monitor.temp_warn = 1'b0;
        tick(8);
        read_st(exp_st(w[6:1], 1'b0, 1'b0, 1'b0, 1'b0));
        $display("TB: prewarning test done");

        xfer(ctl(6'h3F, 1'b1, 1'b0), 16);
        monitor.overcurrent = 6'h01;
        tick(12);
        sw_is(6'h3E, "overcurrent shutdown");
        monitor.overcurrent = 6'h00;
        read_st(exp_st(6'h3E, 1'b0, 1'b1, 1'b0, 1'b0));
        xfer(ctl(6'h3F, 1'b1, 1'b1), 16);
        sw_is(6'h3F, "re-enabled by clear");
        read_st(exp_st(6'h3F, 1'b0, 1'b0, 1'b0, 1'b0));
        xfer(ctl(6'h3F, 1'b0, 1'b0), 16);
        monitor.overcurrent = 6'h02;
        tick(12);
        sw_is(6'h3F, "no shutdown when disabled");
        monitor.overcurrent = 6'h00;
        read_st(exp_st(6'h3F, 1'b0, 1'b1, 1'b0, 1'b0));
        xfer(ctl(6'h3F, 1'b1, 1'b1), 16);
        $display("TB: overcurrent test done");

        monitor.undercurrent = 6'h04;
        tick(12);
        monitor.undercurrent = 6'h00;
        read_st(exp_st(6'h3F, 1'b0, 1'b0, 1'b1, 1'b0));
        xfer(ctl(6'h3F, 1'b1, 1'b1), 16);
        read_st(exp_st(6'h3F, 1'b0, 1'b0, 1'b0, 1'b0));
        $display("TB: open load test done");

        monitor.supply_low = 1'b1;
        tick(12);
        sw_is(6'h00, "undervoltage off");
        monitor.supply_low = 1'b0;
        tick(8);
        sw_is(6'h3F, "supply recovered");
        xfer(ctl(6'h3F, 1'b1, 1'b0), 16);
        check(st, exp_st(6'h3F, 1'b0, 1'b0, 1'b0, 1'b1), "supply fail sticky");
        xfer(ctl(6'h3F, 1'b1, 1'b1), 16);
        xfer(ctl(6'h3F, 1'b1, 1'b0), 16);
        check(st, exp_st(6'h3F, 1'b0, 1'b0, 1'b0, 1'b0), "supply fail cleared");
        $display("TB: supply test done");

        monitor.temp_shutdown = 1'b1;
        tick(8);
        sw_is(6'h00, "thermal shutdown");
        read_st(exp_st(6'h00, 1'b0, 1'b0, 1'b0, 1'b0));
        xfer(ctl(6'h3F, 1'b1, 1'b1), 16);
        sw_is(6'h00, "clear while hot");
        monitor.temp_shutdown = 1'b0;
        tick(8);
        sw_is(6'h00, "cool but not cleared");
        xfer(ctl(6'h3F, 1'b1, 1'b1), 16);
        sw_is(6'h3F, "cool and cleared");
        $display("TB: thermal test done");

        standby_control = 1'b0;
        tick(8);
        sw_is(6'h00, "standby off");
        standby_control = 1'b1;
        tick(8);
        sw_is(6'h00, "reset by standby release");
        read_st(16'h0000);
        $display("TB: standby test done");
        close_out();
    end
endmodule
